//--- pcfg_map.svh
// register offsets, field positions and reset values of the port configuration block
// assumes a cpu register port in bank 1 with a register-addressing qualifier
// Notes on behaviour
// RULE1: port 0 pull-up bit one per pin
// RULE2: push-pull or alternate mode forces pull-up off
// RULE3: pull-up register at e2 in bank 1
// RULE4: all configuration bits clear on reset
// RULE5: only register addressing reaches these registers
// RULE6: port 1 low at e3, bits 7-4 unused
// RULE7: port 1 pin 1 modes, 10 is analog 9
// RULE8: port 1 pin 0 modes, 10 is analog 8
// RULE9: port 2 high at e4, pins 7-4
// RULE10: pin 7 serial 0 receive in/out modes
// RULE11: pin 6 serial 0 transmit modes
// RULE12: pin 5 serial 1 receive in/out modes
// RULE13: pin 4 serial 1 transmit modes
// RULE14: port 2 low at e5, pins 3-0
// RULE15: pin 3 timer a capture and output
// RULE16: pin 2 timer a clock, 01 unavailable
// RULE17: port 0 codes 10 and 11 suppress pull-up
`ifndef PCFG_MAP_SVH
`define PCFG_MAP_SVH
`define PCFG_ADDR_P0_PULLUP   8'he2
`define PCFG_ADDR_P1_MODE_LO  8'he3
`define PCFG_ADDR_P2_MODE_HI  8'he4
`define PCFG_ADDR_P2_MODE_LO  8'he5
`define PCFG_RESET_VALUE      8'h00
`define PCFG_P1_USED_MASK     8'h0f
`define PCFG_MODE_SCHMITT     2'h0
`define PCFG_MODE_ALT_LOW     2'h1
`define PCFG_MODE_ALT_HIGH    2'h2
`define PCFG_MODE_PUSH_PULL   2'h3
`endif

//--- pcfg_pkg.sv
// types shared by the port configuration block
// assumes pcfg_map.svh supplies the numeric constants
package pcfg_pkg;
  typedef struct packed {
    logic [7:0] port0_pullup_enable;
    logic [7:0] port1_mode_low;
    logic [7:0] port2_mode_high;
    logic [7:0] port2_mode_low;
  } pcfg_regs_t;
  // per pin pad control
  typedef struct packed {
    logic pull_up;   // pull-up resistor on
    logic drive_oe_n; // low while the pad is driven
    logic drive_val; // level driven
  } pcfg_pad_t;
endpackage

//--- pcfg_pullup_gate.sv
// gates each port 0 pull-up enable with that pin's mode field
// assumes port 0 mode fields arrive from the port 0 control logic
`timescale 1ns/1ps
module pcfg_pullup_gate #(
  parameter int PINS = 8
) (
  input  wire logic [PINS-1:0]   enable,     // stored pull-up bits
  input  wire logic [2*PINS-1:0] mode,       // port 0 mode fields
  output logic      [PINS-1:0]   pull_up     // effective pull-up per pin
);
  // codes 10 and 11 both have the upper bit set
  for (genvar i = 0; i < PINS; i++) begin : g_pin
    assign pull_up[i] = enable[i] & ~mode[2*i+1]; // RULE2 RULE17 RULE1
  end
endmodule

//--- pcfg_pad_mux.sv
// one port 2 pad: picks drive and enable from a 2-bit mode field
// assumes alt_low_val carries the peripheral output for mode 01
`timescale 1ns/1ps
`include "pcfg_map.svh"
module pcfg_pad_mux #(
  parameter bit ALT_ALLOWED = 1'b1
) (
  input  wire logic [1:0]   mode,        // pin mode field
  input  wire logic         out_val,     // port data latch bit
  input  wire logic         alt_low_val, // peripheral output for mode 01
  output pcfg_pkg::pcfg_pad_t pad        // pad control
);
  // open-drain drives only a low level, push-pull drives both
  always_comb begin
    pad = '0;
    pad.drive_oe_n = 1'b1;
    unique case (mode)
      `PCFG_MODE_SCHMITT:   pad.drive_oe_n = 1'b1;
      `PCFG_MODE_ALT_LOW: begin
        pad.drive_oe_n = ~ALT_ALLOWED; // RULE16
        pad.drive_val  = alt_low_val;
      end
      `PCFG_MODE_ALT_HIGH: begin
        pad.drive_oe_n = out_val;
        pad.drive_val  = 1'b0;
      end
      `PCFG_MODE_PUSH_PULL: begin
        pad.drive_oe_n = 1'b0;
        pad.drive_val  = out_val;
      end
    endcase
  end
endmodule

//--- pcfg_port_regs.sv
// port configuration registers for ports 0, 1 and 2 with pad control
// assumes a cpu register port with a register-addressing qualifier and bank select
`timescale 1ns/1ps
`include "pcfg_map.svh"
module pcfg_port_regs (
  input  wire logic        ref_clk,         // core clock, 20 MHz
  input  wire logic        rst_n,           // synchronous reset, active low
  input  wire logic        reg_sel,         // access uses register addressing
  input  wire logic        bank1,           // register bank 1 selected
  input  wire logic [7:0]  reg_addr,        // register address
  input  wire logic        reg_wr,          // write strobe
  input  wire logic [7:0]  reg_wdata,       // write data
  output logic      [7:0]  reg_rdata,       // read data, zero when unmapped
  output logic             reg_hit,         // address maps to this block
  input  wire logic [15:0] port0_mode,      // port 0 mode fields from port 0 control
  input  wire logic [1:0]  port1_out,       // port 1 data latch bits
  input  wire logic [7:0]  port2_out,       // port 2 data latch bits
  input  wire logic [7:0]  port2_pin_in,    // port 2 pad levels, asynchronous
  input  wire logic        serial0_receive_out,  // serial 0 receive driven out
  input  wire logic        serial0_transmit,     // serial 0 transmit data
  input  wire logic        serial1_receive_out,  // serial 1 receive driven out
  input  wire logic        serial1_transmit,     // serial 1 transmit data
  input  wire logic        timer_a_output,       // timer a output data
  output logic      [7:0]  port0_pull_up,   // effective port 0 pull-ups
  output logic      [1:0]  port1_pull_up,   // port 1 pull-ups
  output logic      [1:0]  port1_oe_n,      // port 1 drive enables, low drives
  output logic      [1:0]  port1_val,       // port 1 drive levels
  output logic             analog_channel_8, // pin routed to analog channel 8
  output logic             analog_channel_9, // pin routed to analog channel 9
  output logic      [7:0]  port2_oe_n,      // port 2 drive enables, low drives
  output logic      [7:0]  port2_val,       // port 2 drive levels
  output logic             serial0_receive,   // synchronised receive input
  output logic             serial1_receive,   // synchronised receive input
  output logic             timer_a_capture_in, // synchronised capture input
  output logic             timer_a_ext_clock   // synchronised timer clock input
);
  // all state of the block
  typedef struct packed {
    pcfg_pkg::pcfg_regs_t regs;
    logic [7:0] sync1;
    logic [7:0] sync2;
  } pcfg_state_t;

  pcfg_state_t state;
  pcfg_state_t next_state;
  logic        access;
  pcfg_pkg::pcfg_pad_t pad [8];

  // address decode: bank 1 under register addressing only
  function automatic logic is_addr(input logic [7:0] a, input logic [7:0] target);
    return a == target;
  endfunction

  assign access = reg_sel & bank1; // RULE5

  // write path and pad synchroniser
  always_comb begin
    next_state       = state;
    next_state.sync1 = port2_pin_in;
    next_state.sync2 = state.sync1;
    if (access && reg_wr) begin
      if (is_addr(reg_addr, `PCFG_ADDR_P0_PULLUP)) begin
        next_state.regs.port0_pullup_enable = reg_wdata; // RULE3 RULE1
      end
      if (is_addr(reg_addr, `PCFG_ADDR_P1_MODE_LO)) begin
        next_state.regs.port1_mode_low = reg_wdata & `PCFG_P1_USED_MASK; // RULE6
      end
      if (is_addr(reg_addr, `PCFG_ADDR_P2_MODE_HI)) begin
        next_state.regs.port2_mode_high = reg_wdata; // RULE9
      end
      if (is_addr(reg_addr, `PCFG_ADDR_P2_MODE_LO)) begin
        next_state.regs.port2_mode_low = reg_wdata; // RULE14
      end
    end
  end

  // register the state
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state.regs  <= {4{`PCFG_RESET_VALUE}}; // RULE4
      state.sync1 <= 8'h00;
      state.sync2 <= 8'h00;
    end else begin
      state <= next_state;
    end
  end

  // read path, unmapped addresses read zero
  always_comb begin
    reg_rdata = 8'h00;
    reg_hit   = 1'b0;
    if (access) begin
      reg_hit = 1'b1;
      if (is_addr(reg_addr, `PCFG_ADDR_P0_PULLUP)) begin
        reg_rdata = state.regs.port0_pullup_enable;
      end else if (is_addr(reg_addr, `PCFG_ADDR_P1_MODE_LO)) begin
        reg_rdata = state.regs.port1_mode_low;
      end else if (is_addr(reg_addr, `PCFG_ADDR_P2_MODE_HI)) begin
        reg_rdata = state.regs.port2_mode_high;
      end else if (is_addr(reg_addr, `PCFG_ADDR_P2_MODE_LO)) begin
        reg_rdata = state.regs.port2_mode_low;
      end else begin
        reg_hit = 1'b0;
      end
    end
  end

  // port 0 pull-up suppression
  pcfg_pullup_gate #(.PINS(8)) u_pullup (
    .enable  (state.regs.port0_pullup_enable),
    .mode    (port0_mode),
    .pull_up (port0_pull_up)
  );

  // port 1 pins: 00 input, 01 input with pull-up, 10 analog, 11 push-pull
  for (genvar p = 0; p < 2; p++) begin : g_port1
    logic [1:0] m;
    assign m = state.regs.port1_mode_low[2*p+1:2*p];
    assign port1_pull_up[p] = (m == `PCFG_MODE_ALT_LOW);             // RULE7 RULE8
    assign port1_oe_n[p]    = ~(m == `PCFG_MODE_PUSH_PULL);          // RULE7 RULE8
    assign port1_val[p]     = port1_out[p];
  end
  assign analog_channel_9 = state.regs.port1_mode_low[3:2] == `PCFG_MODE_ALT_HIGH; // RULE7
  assign analog_channel_8 = state.regs.port1_mode_low[1:0] == `PCFG_MODE_ALT_HIGH; // RULE8

  // port 2 pins 7..4 from the high register, 3..0 from the low register
  logic [5:0] alt_val;
  logic [1:0] p2_mode [8];
  assign alt_val = {serial0_receive_out, serial0_transmit, serial1_receive_out,
                    serial1_transmit, timer_a_output, 1'b0};
  assign p2_mode[7] = state.regs.port2_mode_high[7:6]; // RULE10
  assign p2_mode[6] = state.regs.port2_mode_high[5:4]; // RULE11
  assign p2_mode[5] = state.regs.port2_mode_high[3:2]; // RULE12
  assign p2_mode[4] = state.regs.port2_mode_high[1:0]; // RULE13
  assign p2_mode[3] = state.regs.port2_mode_low[7:6];  // RULE15
  assign p2_mode[2] = state.regs.port2_mode_low[5:4];  // RULE16
  assign p2_mode[1] = state.regs.port2_mode_low[3:2];
  assign p2_mode[0] = state.regs.port2_mode_low[1:0];

  for (genvar q = 2; q < 8; q++) begin : g_port2
    pcfg_pad_mux #(.ALT_ALLOWED(q != 2)) u_pad (
      .mode        (p2_mode[q]),
      .out_val     (port2_out[q]),
      .alt_low_val (alt_val[q-2]),
      .pad         (pad[q])
    );
    assign port2_oe_n[q] = pad[q].drive_oe_n;
    assign port2_val[q]  = pad[q].drive_val;
  end

  // pins 1 and 0 belong to other logic: plain open-drain and push-pull only
  for (genvar r = 0; r < 2; r++) begin : g_port2_low
    assign port2_oe_n[r] = (p2_mode[r] == `PCFG_MODE_PUSH_PULL) ? 1'b0 :
                           (p2_mode[r] == `PCFG_MODE_ALT_HIGH) ? port2_out[r] : 1'b1;
    assign port2_val[r]  = (p2_mode[r] == `PCFG_MODE_PUSH_PULL) & port2_out[r];
  end
  assign pad[0] = '0;
  assign pad[1] = '0;

  // peripheral inputs only in schmitt input mode, from the second sync stage
  assign serial0_receive    = (p2_mode[7] == `PCFG_MODE_SCHMITT) & state.sync2[7]; // RULE10
  assign serial1_receive    = (p2_mode[5] == `PCFG_MODE_SCHMITT) & state.sync2[5]; // RULE12
  assign timer_a_capture_in = (p2_mode[3] == `PCFG_MODE_SCHMITT) & state.sync2[3]; // RULE15
  assign timer_a_ext_clock  = (p2_mode[2] == `PCFG_MODE_SCHMITT) & state.sync2[2]; // RULE16
endmodule

//--- pcfg_port_regs_monitor.sv
// checker for the port configuration block
// assumes it is bound to pcfg_port_regs and sees only its ports
`timescale 1ns/1ps
module pcfg_port_regs_monitor (
  input wire logic        ref_clk,            // clock
  input wire logic        rst_n,              // reset
  input wire logic        reg_sel,            // register addressing
  input wire logic        bank1,              // bank 1
  input wire logic [7:0]  reg_addr,           // address
  input wire logic        reg_wr,             // write
  input wire logic [7:0]  reg_wdata,          // write data
  input wire logic [7:0]  reg_rdata,          // read data
  input wire logic        reg_hit,            // decode
  input wire logic [15:0] port0_mode,         // port 0 modes
  input wire logic [7:0]  port0_pull_up,      // port 0 pull-ups
  input wire logic [1:0]  port1_pull_up,      // port 1 pull-ups
  input wire logic [1:0]  port1_oe_n,         // port 1 enables
  input wire logic        analog_channel_8,   // analog 8
  input wire logic        analog_channel_9,   // analog 9
  input wire logic [7:0]  port2_oe_n,         // port 2 enables
  input wire logic [7:0]  port2_pin_in,       // port 2 pads
  input wire logic        serial0_receive,    // synced receive
  input wire logic        timer_a_capture_in  // synced capture
);
  logic [7:0] upper;
  // upper bit of each port 0 mode field
  always_comb for (int i = 0; i < 8; i++) upper[i] = port0_mode[2*i+1];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_acc; reg_sel && bank1; endsequence
  sequence s_wr; s_acc ##0 reg_wr && reg_hit; endsequence
  a_pullup_gate: assert property ((port0_pull_up & upper) == 8'h00)
    else $error("pull-up on in output mode");
  a_write_read_back: assert property (s_wr ##1 (s_acc ##0 reg_addr == $past(reg_addr)
    && reg_addr != 8'he3) |-> reg_rdata == $past(reg_wdata)) else $error("write not kept");
  a_unsel_quiet: assert property (!(reg_sel && bank1) |-> !reg_hit && reg_rdata == 8'h00)
    else $error("access without register addressing");
  a_addr_decode: assert property (s_acc |-> reg_hit == (reg_addr >= 8'he2 && reg_addr <= 8'he5))
    else $error("bad decode");
  a_p1_unused_zero: assert property (s_acc ##0 reg_addr == 8'he3 |-> reg_rdata[7:4] == 4'h0)
    else $error("unused bits read set");
  a_reset_clear: assert property ($rose(rst_n) |-> port2_oe_n == 8'hff && port0_pull_up == 8'h00
    && port1_pull_up == 2'h0 && port1_oe_n == 2'h3) else $error("not cleared by reset");
  a_analog_8_only: assert property (analog_channel_8 |-> port1_oe_n[0] && !port1_pull_up[0])
    else $error("analog 8 mixed");
  a_analog_9_only: assert property (analog_channel_9 |-> port1_oe_n[1] && !port1_pull_up[1])
    else $error("analog 9 mixed");
  a_rx_sync_delay: assert property ($rose(serial0_receive) |-> $past(port2_pin_in[7], 2))
    else $error("receive rose early");
  a_cap_sync_delay: assert property ($rose(timer_a_capture_in) |-> $past(port2_pin_in[3], 2))
    else $error("capture rose early");
endmodule
bind pcfg_port_regs pcfg_port_regs_monitor pcfg_port_regs_monitor_inst (.ref_clk, .rst_n,
  .reg_sel, .bank1, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .reg_hit, .port0_mode,
  .port0_pull_up, .port1_pull_up, .port1_oe_n, .analog_channel_8, .analog_channel_9,
  .port2_oe_n, .port2_pin_in, .serial0_receive, .timer_a_capture_in);

//--- pcfg_pin_model.sv
// port 2 pads with an outside driver
// assumes no pull-ups on port 2, so released pins float
`timescale 1ns/1ps
module pcfg_pin_model (
  input  wire logic       ref_clk, // clock
  input  wire logic [7:0] oe_n,    // pad enables, low drives
  input  wire logic [7:0] val,     // pad levels
  input  wire logic [7:0] ext,     // outside level
  input  wire logic       ext_en,  // outside driver on
  output logic      [7:0] pin      // pad levels seen
);
  logic [7:0] churn = 8'h00;
  // a floating pin 7, 5, 2 or 0 toggles every cycle, pins 6, 4, 3 and 1 stay low
  always @(posedge ref_clk) churn <= ~churn ^ 8'h5a;
  // the pad wins, then the outside driver
  always_comb for (int i = 0; i < 8; i++) pin[i] = !oe_n[i] ? val[i] : ext_en ? ext[i] : churn[i];
endmodule

//--- pcfg_port_regs_bench.sv
// self-checking bench for the port configuration block
// assumes the pin model and the bound checker
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %0t got %h want %h", $time, g, e); end end
module pcfg_port_regs_bench;
  logic ref_clk = 0, rst_n = 0, reg_sel = 0, bank1 = 0, reg_wr = 0, chk_go = 0, ext_en = 1;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, port2_out = 8'h00, ext = 8'h00;
  logic [15:0] port0_mode = 16'h0000;
  logic [1:0] port1_out = 2'h0;
  logic [4:0] alt = 5'h00;
  logic [7:0] reg_rdata, port0_pull_up, port2_oe_n, port2_val, port2_pin_in, v, r, e, eo, ev;
  logic [1:0] port1_pull_up, port1_oe_n, port1_val;
  logic reg_hit, analog_channel_8, analog_channel_9;
  logic serial0_receive, serial1_receive, timer_a_capture_in, timer_a_ext_clock;
  logic [7:0] q[$], want;
  int chk_kind = 0, error_cnt = 0, num_checks = 0, cycles = 0, seed = 32'hc864;
  always #25 ref_clk = ~ref_clk;
  pcfg_port_regs pcfg_port_regs_inst (.ref_clk, .rst_n, .reg_sel, .bank1, .reg_addr, .reg_wr,
    .reg_wdata, .reg_rdata, .reg_hit, .port0_mode, .port1_out, .port2_out, .port2_pin_in,
    .serial0_receive_out(alt[4]), .serial0_transmit(alt[3]), .serial1_receive_out(alt[2]),
    .serial1_transmit(alt[1]), .timer_a_output(alt[0]), .port0_pull_up, .port1_pull_up,
    .port1_oe_n, .port1_val, .analog_channel_8, .analog_channel_9, .port2_oe_n, .port2_val,
    .serial0_receive, .serial1_receive, .timer_a_capture_in, .timer_a_ext_clock);
  pcfg_pin_model pcfg_pin_model_inst (.ref_clk, .oe_n(port2_oe_n), .val(port2_val), .ext,
    .ext_en, .pin(port2_pin_in));
  // picks the output group a note refers to
  function automatic logic [7:0] pick(input int k);
    case (k)
      0: pick = reg_rdata;
      1: pick = port2_oe_n;
      2: pick = port2_val & ~port2_oe_n;
      3: pick = port0_pull_up;
      4: pick = {analog_channel_9, analog_channel_8, port1_pull_up, port1_oe_n,
                 port1_val & ~port1_oe_n};
      6: pick = {7'h0, reg_hit};
      default: pick = {4'h0, serial0_receive, serial1_receive, timer_a_capture_in,
                       timer_a_ext_clock};
    endcase
  endfunction
  task automatic final_report;
    if (error_cnt == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // one register write, access qualifiers given as {reg_sel, bank1}
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] sb = 2'h3);
    @(negedge ref_clk);
    {reg_sel, bank1} = sb;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    @(negedge ref_clk);
    reg_wr = 0;
  endtask
  // notes an expected value; the watcher compares it at the next edge
  task automatic obs(input int k, input logic [7:0] a, input logic [7:0] x);
    @(negedge ref_clk);
    {reg_sel, bank1} = 2'h3;
    reg_addr = a;
    chk_kind = k;
    q.push_back(x);
    chk_go = 1;
    @(negedge ref_clk);
    chk_go = 0;
  endtask
  // watcher takes the oldest note whenever a result is due
  always @(posedge ref_clk) if (chk_go) begin
    want = q.pop_front();
    `CHK(pick(chk_kind), want)
  end
  // hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      final_report();
    end
  end
  initial begin
    repeat (10) @(negedge ref_clk);
    rst_n = 1;
    for (int k = 0; k < 4; k++) obs(0, 8'he2 + k[7:0], 8'h00);
    obs(0, 8'he6, 8'h00);
    obs(6, 8'he6, 8'h00);
    obs(6, 8'he5, 8'h01);
    v = $random(seed);
    wr(8'he2, v);
    obs(0, 8'he2, v);
    obs(3, 8'he2, v);
    wr(8'he2, ~v, 2'h1);
    wr(8'he2, ~v, 2'h2);
    obs(0, 8'he2, v);
    for (int c = 0; c < 4; c++) begin
      r = $random(seed);
      e = $random(seed);
      @(negedge ref_clk);
      {alt, port2_out, ext} = {r[4:0], r, e | (c == 0 ? 8'h88 : 8'h00)};
      port1_out = r[1:0];
      port0_mode = {8{c[1:0]}};
      wr(8'he4, {4{c[1:0]}});
      wr(8'he5, {4{c[1:0]}});
      wr(8'he3, {4'hf, c[1:0], c[1:0]});
      case (c)
        0: {eo, ev} = {8'hff, 8'h00};
        1: {eo, ev} = {8'h07, r[4:0], 3'h0};
        2: {eo, ev} = {r, 8'h00};
        default: {eo, ev} = {8'h00, r};
      endcase
      obs(0, 8'he3, {4'h0, c[1:0], c[1:0]});
      obs(1, 8'he4, eo);
      obs(2, 8'he5, ev);
      obs(3, 8'he2, c[1] ? 8'h00 : v);
      obs(4, 8'he3, {c == 2, c == 2, c == 1, c == 1, c != 3, c != 3, c == 3 ? r[1:0] : 2'h0});
      obs(5, 8'he3, c == 0 ? {4'h0, ext[7], ext[5], ext[3], ext[2]} : 8'h00);
    end
    final_report();
  end
endmodule
